// *** bench/epba_mem_model.sv ***
`timescale 1ns/100ps
module epba_mem_model import epba_pkg::*; (
	// Clock
	input  wire logic              clk,
	// External port
	input  wire logic [EXT_AW-1:0] ext_addr,
	input  wire logic              rd_strobe_n,
	output logic [EXT_DW-1:0]      ext_data_in,
	output logic                   ext_ack
);
	logic [EXT_DW-1:0] last_q = 16'h0000;

	// Undriven bus shows the inverse of the last word, so stale data never matches
	always_comb begin
		if (rd_strobe_n === 1'b0) begin
			ext_data_in = ext_addr[EXT_DW-1:0] ^ 16'h5A5A;
		end else begin
			ext_data_in = ~last_q;
		end
	end

	always_ff @(posedge clk) begin
		if (rd_strobe_n === 1'b0) begin
			last_q <= ext_data_in;
		end
	end

	assign ext_ack = 1'b1;
endmodule

// *** bench/external_port_bus_arbiter_bench.sv ***
`timescale 1ns/100ps
module external_port_bus_arbiter_bench import epba_pkg::*;;
	logic              clk = 1'b0;
	logic              por_n = 1'b0;
	logic              nrst = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [APB_AW-1:0] paddr = '0;
	logic [APB_DW-1:0] pwdata = '0;
	logic [APB_DW-1:0] prdata;
	logic              pready;
	logic              pslverr;
	epba_req_t         core_req = '0;
	epba_req_t         dma_acc = '0;
	logic              core_done;
	logic [WORD_W-1:0] core_rdata;
	logic [NUM_DMA-1:0] dma_req = '0;
	logic [NUM_DMA-1:0] dma_sel;
	logic              dma_done;
	logic [2:0]        dma_done_ch;
	logic              onchip;
	logic [EXT_AW-1:0] ext_addr;
	logic [EXT_DW-1:0] ext_data_in;
	logic [EXT_DW-1:0] ext_data_out;
	logic              ext_addr_oe;
	logic              ext_data_oe;
	logic              ctrl_oe;
	logic [3:0]        bank_n;
	logic              io_n;
	logic              boot_n;
	logic              rd_n;
	logic              wr_n;
	logic              ext_ack;
	logic              request_n = 1'b1;
	logic              grant_n;
	logic              hang_n;
	logic              core_wide = 1'b0;
	logic              core_lock = 1'b0;
	int                error_cnt = 0;
	int                comparisons = 0;

	always #12.5 clk = ~clk;

	epba_top dut_u (.clk(clk), .por_n(por_n), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .core_req(core_req), .core_done(core_done),
		.core_rdata(core_rdata), .dma_req(dma_req), .dma_acc(dma_acc), .dma_sel(dma_sel),
		.dma_done(dma_done), .dma_done_ch(dma_done_ch), .onchip_io_strobe(onchip),
		.ext_addr(ext_addr), .ext_addr_oe(ext_addr_oe), .ext_data_in(ext_data_in),
		.ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe), .bank_select_n(bank_n),
		.io_space_select_n(io_n), .boot_space_select_n(boot_n), .rd_strobe_n(rd_n),
		.wr_strobe_n(wr_n), .ctrl_oe(ctrl_oe), .ext_ack(ext_ack),
		.external_bus_request_n(request_n), .external_bus_grant_n(grant_n),
		.grant_hang_n(hang_n));

	epba_mem_model mem_u (.clk(clk), .ext_addr(ext_addr), .rd_strobe_n(rd_n),
		.ext_data_in(ext_data_in), .ext_ack(ext_ack));

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Seen bits: onchip, boot, io, bank 3..0
	task automatic core(input epba_space_t sp, input logic [23:0] a, output logic [6:0] seen);
		int n;
		seen = '0;
		n = 0;
		@(posedge clk);
		core_req <= '{1'b1, sp, 1'b0, core_wide, core_lock, a, 24'h000000};
		do begin
			@(posedge clk);
			n++;
			seen = seen | {onchip, ~boot_n, ~io_n, ~bank_n};
		end while (core_done !== 1'b1 && n < 300);
		chk("core done", 1, core_done);
		core_req.valid <= 1'b0;
	endtask

	task automatic t_regs;
		logic [31:0] r;
		logic        e;
		logic [11:0] cfg_a [2] = '{REG_MEM_CFG, REG_BOOT_CFG};
		apb(0, REG_BOUND, 0, r, e);
		chk("bound reset", 32'h00C08040, r);
		for (int i = 0; i < 2; i++) begin
			apb(0, cfg_a[i], 0, r, e);
			chk("space cfg reset", 32'h00000800, r);
		end
		apb(0, REG_IO_CFG, 0, r, e);
		chk("io cfg reset", 32'h00000800, r);
		apb(0, 12'h0F0, 0, r, e);
		chk("unmapped err", 1, e);
		$display("test regs done");
	endtask

	task automatic t_decode;
		logic [7:0]  pg [8] = '{8'h01, 8'h3F, 8'h40, 8'h7F, 8'h80, 8'hBF, 8'hC0, 8'hFE};
		logic [6:0]  s;
		logic [31:0] r;
		logic        e;
		for (int i = 0; i < 8; i++) begin
			core(SPC_MEM, {pg[i], 16'h0123}, s);
			chk("bank sel", 32'(1) << (i / 2), s);
			chk("read word", 16'h0123 ^ 16'h5A5A, core_rdata[15:0]);
		end
		apb(1, REG_BOUND, 32'h00C08020, r, e);
		core(SPC_MEM, 24'h300010, s);
		chk("moved bound", 2, s);
		core(SPC_IO, 24'h001400, s);
		chk("io onchip", 7'h40, s);
		core(SPC_IO, 24'h008000, s);
		chk("io external", 7'h10, s);
		core(SPC_BOOT, 24'h010000, s);
		chk("boot sel", 7'h20, s);
		// Byte-wide boot space, 24-bit word: three beats, low byte first
		apb(1, REG_BOOT_CFG, 32'h00000000, r, e);
		core_wide = 1'b1;
		core(SPC_BOOT, 24'h010000, s);
		core_wide = 1'b0;
		chk("packed word", 24'h585B5A, core_rdata);
		$display("test decode done");
	endtask

	task automatic t_grant;
		int         n;
		logic [6:0] s;
		n = 0;
		request_n <= 1'b0;
		do begin
			@(posedge clk);
			n++;
		end while (grant_n !== 1'b0 && n < 40);
		chk("grant delay", 1, n >= GRANT_MIN_CYC);
		chk("oe at grant", 0, {ext_addr_oe, ext_data_oe, ctrl_oe});
		fork
			core(SPC_MEM, 24'h400004, s);
			begin
				repeat (10) @(posedge clk);
				chk("stalled", 0, core_done);
				chk("hang", 0, hang_n);
				request_n <= 1'b1;
			end
		join
		chk("grant off", 1, grant_n);
		chk("resumed sel", 2, s);
		nrst <= 1'b0;
		request_n <= 1'b0;
		repeat (12) @(posedge clk);
		chk("grant in reset", 0, grant_n);
		request_n <= 1'b1;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		$display("test grant done");
	endtask

	task automatic t_lock;
		logic [6:0]  s;
		logic [31:0] r;
		logic        e;
		core_lock = 1'b1;
		core(SPC_MEM, 24'h010000, s);
		core_lock = 1'b0;
		request_n <= 1'b0;
		repeat (8) @(posedge clk);
		chk("grant in pair", 1, grant_n);
		core(SPC_MEM, 24'h010001, s);
		repeat (6) @(posedge clk);
		chk("grant after pair", 0, grant_n);
		apb(0, REG_STATUS, 0, r, e);
		chk("status", 7'h09, r[6:0]);
		request_n <= 1'b1;
		repeat (6) @(posedge clk);
		$display("test lock done");
	endtask

	task automatic t_excl;
		logic [31:0] r;
		logic        e;
		apb(1, REG_CTRL, 32'h00000001, r, e);
		request_n <= 1'b0;
		repeat (20) @(posedge clk);
		chk("excl grant", 1, grant_n);
		request_n <= 1'b1;
		apb(1, REG_CTRL, 32'h00000000, r, e);
		$display("test excl done");
	endtask

	task automatic t_dma;
		int n;
		for (int k = 0; k < NUM_DMA; k++) begin
			dma_req <= 5'h1F << k;
			@(posedge clk);
			chk("dma sel", 32'(1) << k, dma_sel);
		end
		// The sweep starts port cycles of its own; let them drain first
		dma_req <= '0;
		repeat (4) @(posedge clk);
		dma_acc <= '{1'b1, SPC_MEM, 1'b0, 1'b0, 1'b0, 24'h800010, 24'h000000};
		dma_req <= 5'b00100;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (dma_done !== 1'b1 && n < 300);
		chk("dma channel", 2, dma_done_ch);
		chk("dma word", 16'h0010 ^ 16'h5A5A, core_rdata[15:0]);
		dma_req <= '0;
		dma_acc.valid <= 1'b0;
		$display("test dma done");
	endtask

	initial begin
		repeat (6) @(posedge clk);
		por_n <= 1'b1;
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		t_regs();
		t_decode();
		t_grant();
		t_lock();
		t_excl();
		t_dma();
		conclude();
	end

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		conclude();
	end
endmodule

// *** core/epba_pack.sv ***
`timescale 1ns/100ps
module epba_pack import epba_pkg::*; (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// Control
	input  wire logic              start,
	input  wire logic              beat_done,
	input  wire logic              capture,
	input  wire logic              width16,
	input  wire logic              wide24,
	// Data
	input  wire logic [EXT_DW-1:0] bus_in,
	input  wire logic [WORD_W-1:0] wdata,
	output logic [EXT_DW-1:0]      wr_bus,
	output logic [WORD_W-1:0]      rdata,
	output logic [1:0]             nbeats,
	output logic [1:0]             beat,
	output logic                   last
);
	epba_pack_t s_q;
	epba_pack_t s_d;
	logic [4:0]        lsb;
	logic [EXT_DW-1:0] lane_in;

	always_comb begin
		s_d = s_q;
		nbeats = width16 ? (wide24 ? 2'h2 : 2'h1) : (wide24 ? 2'h3 : 2'h2);
		lsb = width16 ? 5'(s_q.beat) << 4 : 5'(s_q.beat) << 3;
		lane_in = width16 ? bus_in : {8'h00, bus_in[BYTE_W-1:0]};
		wr_bus = EXT_DW'(wdata >> lsb);
		last = (s_q.beat == nbeats - 2'h1);
		if (start) begin
			s_d.beat = 2'h0;
			s_d.rword = '0;
		end else begin
			if (capture)
				s_d.rword = s_q.rword | WORD_W'({8'h00, lane_in} << lsb);
			if (beat_done)
				s_d.beat = s_q.beat + 2'h1;
		end
	end

	assign beat = s_q.beat;
	assign rdata = s_q.rword;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end
endmodule

// *** core/epba_pkg.sv ***
package epba_pkg;
	localparam int EXT_AW      = 20;
	localparam int EXT_DW      = 16;
	localparam int CPU_AW      = 24;
	localparam int WORD_W      = 24;
	localparam int BYTE_W      = 8;
	localparam int NUM_BANK    = 4;
	localparam int NUM_DMA     = 5;
	localparam int DMA_IDX_W   = 3;
	localparam int APB_AW      = 12;
	localparam int APB_DW      = 32;
	localparam int PAGE_LSB    = 16;
	localparam int IO_PAGE_LSB = 10;
	localparam int PAGE_W      = 8;

	// Bank boundaries after reset: first page of banks 1 to 3
	localparam logic [PAGE_W-1:0] BANK1_FIRST_RST = 8'h40;
	localparam logic [PAGE_W-1:0] BANK2_FIRST_RST = 8'h80;
	localparam logic [PAGE_W-1:0] BANK3_FIRST_RST = 8'hC0;
	localparam logic [PAGE_W-1:0] IO_EXT_FIRST    = 8'h20;

	// Grant delay and clock limits
	localparam int GRANT_MIN_CYC = 3;
	localparam int CLK_HZ        = 40_000_000;
	localparam int PCLK_MAX_HZ   = 80_000_000;

	// Register map (byte addresses)
	localparam logic [APB_AW-1:0] REG_CTRL     = 12'h000;
	localparam logic [APB_AW-1:0] REG_MEM_CFG  = 12'h004;
	localparam logic [APB_AW-1:0] REG_IO_CFG   = 12'h008;
	localparam logic [APB_AW-1:0] REG_BOOT_CFG = 12'h00C;
	localparam logic [APB_AW-1:0] REG_BOUND    = 12'h010;
	localparam logic [APB_AW-1:0] REG_STATUS   = 12'h014;
	localparam int CTRL_EXCL_BIT  = 0;
	localparam int BOUND_B1_LSB   = 0;
	localparam int BOUND_B2_LSB   = 8;
	localparam int BOUND_B3_LSB   = 16;
	localparam int ST_GRANTED_BIT = 0;
	localparam int ST_HANG_BIT    = 1;
	localparam int ST_LOCK_BIT    = 2;
	localparam int ST_BUSY_BIT    = 3;
	localparam int ST_DMA_LSB     = 4;

	typedef struct packed {
		logic       width16;
		logic       strobe_inv;
		logic       wr_hold;
		logic [1:0] clk_div;
		logic       wait_ack;
		logic [2:0] wr_wait;
		logic [2:0] rd_wait;
	} epba_space_cfg_t;
	localparam int SPACE_CFG_W = $bits(epba_space_cfg_t);
	localparam epba_space_cfg_t SPACE_CFG_RST = 12'h800;

	typedef enum logic [1:0] {SPC_MEM, SPC_IO, SPC_BOOT} epba_space_t;

	typedef struct packed {
		logic              valid;
		epba_space_t       space;
		logic              write;
		logic              wide24;
		logic              lock;
		logic [CPU_AW-1:0] addr;
		logic [WORD_W-1:0] wdata;
	} epba_req_t;

	typedef enum logic [2:0] {
		B_IDLE, B_NEXT, B_STROBE, B_HOLD, B_FLOAT, B_GRANT, B_RECLAIM
	} epba_bstate_t;

	typedef struct packed {
		epba_bstate_t          state;
		logic                  owner_dma;
		logic [DMA_IDX_W-1:0]  dma_ch;
		epba_req_t             req;
		epba_space_cfg_t       cfg;
		logic [2:0]            cnt;
		logic [1:0]            div;
		logic [EXT_AW-1:0]     addr;
		logic [EXT_DW-1:0]     dout;
		logic                  drive;
		logic                  rd_act;
		logic                  wr_act;
		logic [NUM_BANK-1:0]   bank_act;
		logic                  io_act;
		logic                  boot_act;
		logic                  grant_n;
		logic                  hang_n;
		logic                  lock;
		logic                  br_s1;
		logic                  br_s2;
		logic                  core_done;
		logic                  dma_done;
		logic                  onchip;
	} epba_bus_t;

	typedef struct packed {
		logic              excl;
		epba_space_cfg_t   mem;
		epba_space_cfg_t   io;
		epba_space_cfg_t   boot;
		logic [PAGE_W-1:0] b1;
		logic [PAGE_W-1:0] b2;
		logic [PAGE_W-1:0] b3;
		logic [APB_DW-1:0] prdata;
	} epba_cfg_t;

	typedef struct packed {
		logic [1:0]        beat;
		logic [WORD_W-1:0] rword;
	} epba_pack_t;
endpackage

// *** core/epba_top.sv ***
// Contract
// - Per-space wait, mode, divide, hold, polarity, width
// - Four bank, one I/O, one boot select
// - External data path 8 or 16 bits
// - Reset bank bounds 0/64/128/192 pages
// - Bank bounds movable per 64K page
// - I/O space: 256 pages of 1024
// - I/O pages 0-31 stay on-chip
// - Boot space one bank, boot select
// - External request lowest priority
// - Grant no sooner than three cycles
// - Float all port outputs, then grant
// - Core external access stalls while granted
// - No grant between paired reads
// - Grant allowed between read and write
// - Option: port exclusive to core
// - Request held while used; release ends grant
// - Bus request works during reset
// - Grant-hang when access blocked by grant
// - Fixed DMA priority, receive port highest
// - 16-bit data, 20-bit address port
// - Pack 16/24-bit words over beats
// - Peripheral clock at most 80 MHz
`timescale 1ns/100ps
module epba_top import epba_pkg::*; (
	// Clock and resets
	input  wire logic                  clk,
	input  wire logic                  por_n,
	input  wire logic                  nrst,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [APB_AW-1:0]     paddr,
	input  wire logic [APB_DW-1:0]     pwdata,
	output logic [APB_DW-1:0]          prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Core access port
	input  wire epba_req_t             core_req,
	output logic                       core_done,
	output logic [WORD_W-1:0]          core_rdata,
	// DMA access port
	input  wire logic [NUM_DMA-1:0]    dma_req,
	input  wire epba_req_t             dma_acc,
	output logic [NUM_DMA-1:0]         dma_sel,
	output logic                       dma_done,
	output logic [DMA_IDX_W-1:0]       dma_done_ch,
	output logic                       onchip_io_strobe,
	// External port
	output logic [EXT_AW-1:0]          ext_addr,
	output logic                       ext_addr_oe,
	input  wire logic [EXT_DW-1:0]     ext_data_in,
	output logic [EXT_DW-1:0]          ext_data_out,
	output logic                       ext_data_oe,
	output logic [NUM_BANK-1:0]        bank_select_n,
	output logic                       io_space_select_n,
	output logic                       boot_space_select_n,
	output logic                       rd_strobe_n,
	output logic                       wr_strobe_n,
	output logic                       ctrl_oe,
	input  wire logic                  ext_ack,
	// Bus request handshake
	input  wire logic                  external_bus_request_n,
	output logic                       external_bus_grant_n,
	output logic                       grant_hang_n
);
	logic [1:0]           por_sync_q;
	logic [1:0]           nrst_sync_q;
	logic                 por_s;
	logic                 dev_run;
	epba_cfg_t            c_q;
	epba_cfg_t            c_d;
	epba_bus_t            b_q;
	epba_bus_t            b_d;
	logic                 core_pend;
	logic                 dma_pend;
	logic                 dma_any;
	logic [DMA_IDX_W-1:0] dma_win;
	logic                 ext_ok;
	logic                 tick;
	logic                 adv;
	logic                 beat_end;
	logic                 pk_start;
	epba_req_t            nreq;
	epba_space_cfg_t      ncfg;
	logic [PAGE_W-1:0]    npage;
	logic [PAGE_W-1:0]    nio_page;
	logic                 apb_map;
	logic [APB_DW-1:0]    rd_mux;
	logic [EXT_DW-1:0]    pk_wr;
	logic [1:0]           pk_nbeats;
	logic [1:0]           pk_beat;
	logic                 pk_last;

	// Reset release copies; bus domain keeps its own power-on reset
	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n)
			por_sync_q <= 2'h0;
		else
			por_sync_q <= {por_sync_q[0], 1'b1};
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			nrst_sync_q <= 2'h0;
		else
			nrst_sync_q <= {nrst_sync_q[0], 1'b1};
	end
	assign por_s = por_sync_q[1];
	assign dev_run = nrst_sync_q[1];

	// Fixed priority among DMA masters, lowest index wins
	always_comb begin
		dma_win = '0;
		dma_any = 1'b0;
		for (int i = NUM_DMA - 1; i >= 0; i--) begin
			if (dma_req[i]) begin
				dma_win = DMA_IDX_W'(i);
				dma_any = 1'b1;
			end
		end
	end
	assign dma_sel = dma_any ? (NUM_DMA'(1) << dma_win) : '0;

	// Held-off requests are masked in the completion cycle to avoid a repeat
	assign core_pend = core_req.valid && dev_run && !b_q.core_done;
	assign dma_pend = dma_any && dev_run && !c_q.excl && !b_q.dma_done;
	assign ext_ok = b_q.br_s2 && !b_q.lock && !c_q.excl && !core_pend && !dma_pend;
	assign nreq = core_pend ? core_req : dma_acc;
	assign npage = nreq.addr[PAGE_LSB +: PAGE_W];
	assign nio_page = nreq.addr[IO_PAGE_LSB +: PAGE_W];
	assign tick = (b_q.div == b_q.cfg.clk_div);

	always_comb begin
		case (nreq.space)
			SPC_IO:   ncfg = c_q.io;
			SPC_BOOT: ncfg = c_q.boot;
			default:  ncfg = c_q.mem;
		endcase
	end

	always_comb begin
		b_d = b_q;
		adv = 1'b0;
		beat_end = 1'b0;
		pk_start = 1'b0;
		b_d.br_s1 = !external_bus_request_n;
		b_d.br_s2 = b_q.br_s1;
		b_d.core_done = 1'b0;
		b_d.dma_done = 1'b0;
		b_d.onchip = 1'b0;
		b_d.hang_n = !(b_q.state == B_GRANT && (core_pend || dma_pend));
		b_d.div = (b_q.state == B_STROBE || b_q.state == B_HOLD) && !tick ?
			b_q.div + 2'h1 : 2'h0;
		case (b_q.state)
			B_IDLE: begin
				if (ext_ok) begin
					b_d.drive = 1'b0;
					b_d.state = B_FLOAT;
				end else if (core_pend || dma_pend) begin
					b_d.req = nreq;
					b_d.owner_dma = !core_pend;
					b_d.dma_ch = dma_win;
					if (nreq.space == SPC_IO && nio_page < IO_EXT_FIRST) begin
						b_d.onchip = 1'b1;
						b_d.core_done = core_pend;
						b_d.dma_done = !core_pend;
					end else begin
						b_d.cfg = ncfg;
						b_d.bank_act = '0;
						if (nreq.space == SPC_MEM) begin
							if (npage < c_q.b1)
								b_d.bank_act = 4'h1;
							else if (npage < c_q.b2)
								b_d.bank_act = 4'h2;
							else if (npage < c_q.b3)
								b_d.bank_act = 4'h4;
							else
								b_d.bank_act = 4'h8;
						end
						b_d.io_act = (nreq.space == SPC_IO);
						b_d.boot_act = (nreq.space == SPC_BOOT);
						pk_start = 1'b1;
						b_d.state = B_NEXT;
					end
				end
			end
			B_NEXT: begin
				b_d.addr = (pk_beat == 2'h0) ?
					EXT_AW'(b_q.req.addr[EXT_AW-1:0] * pk_nbeats) : b_q.addr + 20'h00001;
				b_d.dout = pk_wr;
				b_d.rd_act = !b_q.req.write;
				b_d.wr_act = b_q.req.write;
				b_d.cnt = b_q.req.write ? b_q.cfg.wr_wait : b_q.cfg.rd_wait;
				b_d.state = B_STROBE;
			end
			B_STROBE: begin
				if (tick) begin
					if (b_q.cnt != 3'h0)
						b_d.cnt = b_q.cnt - 3'h1;
					else if (!b_q.cfg.wait_ack || ext_ack)
						beat_end = 1'b1;
				end
				if (beat_end) begin
					b_d.rd_act = 1'b0;
					b_d.wr_act = 1'b0;
					if (b_q.req.write && b_q.cfg.wr_hold)
						b_d.state = B_HOLD;
					else
						adv = 1'b1;
				end
			end
			B_HOLD: adv = tick;
			B_FLOAT: begin
				b_d.grant_n = !b_q.br_s2;
				b_d.state = b_q.br_s2 ? B_GRANT : B_RECLAIM;
			end
			B_GRANT: begin
				if (!b_q.br_s2) begin
					b_d.grant_n = 1'b1;
					b_d.state = B_RECLAIM;
				end
			end
			B_RECLAIM: begin
				b_d.drive = 1'b1;
				b_d.state = B_IDLE;
			end
			default: b_d.state = B_IDLE;
		endcase
		if (adv) begin
			if (pk_last) begin
				b_d.bank_act = '0;
				b_d.io_act = 1'b0;
				b_d.boot_act = 1'b0;
				b_d.core_done = !b_q.owner_dma;
				b_d.dma_done = b_q.owner_dma;
				if (!b_q.owner_dma)
					b_d.lock = b_q.req.lock && !b_q.req.write;
				b_d.state = B_IDLE;
			end else begin
				b_d.state = B_NEXT;
			end
		end
		// Device reset drops any access in flight but leaves the grant path alone
		if (!dev_run) begin
			b_d.lock = 1'b0;
			if (b_q.state inside {B_NEXT, B_STROBE, B_HOLD}) begin
				b_d.rd_act = 1'b0;
				b_d.wr_act = 1'b0;
				b_d.bank_act = '0;
				b_d.io_act = 1'b0;
				b_d.boot_act = 1'b0;
				b_d.state = B_IDLE;
			end
		end
	end

	always_ff @(posedge clk or negedge por_s) begin
		if (!por_s) begin
			b_q <= '0;
			b_q.state <= B_IDLE;
			b_q.cfg <= SPACE_CFG_RST;
			b_q.drive <= 1'b1;
			b_q.grant_n <= 1'b1;
			b_q.hang_n <= 1'b1;
		end else begin
			b_q <= b_d;
		end
	end

	epba_pack u_pack (
		.clk       (clk),
		.rst_n     (por_s),
		.start     (pk_start),
		.beat_done (adv),
		.capture   (beat_end && !b_q.req.write),
		.width16   (b_q.cfg.width16),
		.wide24    (b_q.req.wide24),
		.bus_in    (ext_data_in),
		.wdata     (b_q.req.wdata),
		.wr_bus    (pk_wr),
		.rdata     (core_rdata),
		.nbeats    (pk_nbeats),
		.beat      (pk_beat),
		.last      (pk_last)
	);

	// Register file
	assign apb_map = paddr inside {REG_CTRL, REG_MEM_CFG, REG_IO_CFG, REG_BOOT_CFG,
		REG_BOUND, REG_STATUS};
	always_comb begin
		rd_mux = '0;
		case (paddr)
			REG_CTRL:     rd_mux[CTRL_EXCL_BIT] = c_q.excl;
			REG_MEM_CFG:  rd_mux[SPACE_CFG_W-1:0] = c_q.mem;
			REG_IO_CFG:   rd_mux[SPACE_CFG_W-1:0] = c_q.io;
			REG_BOOT_CFG: rd_mux[SPACE_CFG_W-1:0] = c_q.boot;
			REG_BOUND:    rd_mux[BOUND_B3_LSB+PAGE_W-1:0] = {c_q.b3, c_q.b2, c_q.b1};
			REG_STATUS: begin
				rd_mux[ST_GRANTED_BIT] = !b_q.grant_n;
				rd_mux[ST_HANG_BIT] = !b_q.hang_n;
				rd_mux[ST_LOCK_BIT] = b_q.lock;
				rd_mux[ST_BUSY_BIT] = b_q.state != B_IDLE;
				rd_mux[ST_DMA_LSB +: DMA_IDX_W] = b_q.dma_ch;
			end
			default: rd_mux = '0;
		endcase
	end

	always_comb begin
		c_d = c_q;
		if (psel && !penable)
			c_d.prdata = rd_mux;
		if (psel && penable && pwrite) begin
			case (paddr)
				REG_CTRL:     c_d.excl = pwdata[CTRL_EXCL_BIT];
				REG_MEM_CFG:  c_d.mem = pwdata[SPACE_CFG_W-1:0];
				REG_IO_CFG:   c_d.io = pwdata[SPACE_CFG_W-1:0];
				REG_BOOT_CFG: c_d.boot = pwdata[SPACE_CFG_W-1:0];
				REG_BOUND: begin
					c_d.b1 = pwdata[BOUND_B1_LSB +: PAGE_W];
					c_d.b2 = pwdata[BOUND_B2_LSB +: PAGE_W];
					c_d.b3 = pwdata[BOUND_B3_LSB +: PAGE_W];
				end
				default: c_d.excl = c_q.excl;
			endcase
		end
	end

	always_ff @(posedge clk or negedge dev_run) begin
		if (!dev_run) begin
			c_q <= '0;
			c_q.mem <= SPACE_CFG_RST;
			c_q.io <= SPACE_CFG_RST;
			c_q.boot <= SPACE_CFG_RST;
			c_q.b1 <= BANK1_FIRST_RST;
			c_q.b2 <= BANK2_FIRST_RST;
			c_q.b3 <= BANK3_FIRST_RST;
		end else begin
			c_q <= c_d;
		end
	end

	assign prdata = c_q.prdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !apb_map;

	// Pins; polarity bit flips the active level of each space's strobes
	assign core_done = b_q.core_done;
	assign dma_done = b_q.dma_done;
	assign dma_done_ch = b_q.dma_ch;
	assign onchip_io_strobe = b_q.onchip;
	assign ext_addr = b_q.addr;
	assign ext_data_out = b_q.dout;
	assign ext_addr_oe = b_q.drive;
	assign ext_data_oe = b_q.drive && b_q.wr_act;
	assign ctrl_oe = b_q.drive;
	assign bank_select_n = ~b_q.bank_act ^ {NUM_BANK{c_q.mem.strobe_inv}};
	assign io_space_select_n = !b_q.io_act ^ c_q.io.strobe_inv;
	assign boot_space_select_n = !b_q.boot_act ^ c_q.boot.strobe_inv;
	assign rd_strobe_n = !b_q.rd_act ^ b_q.cfg.strobe_inv;
	assign wr_strobe_n = !b_q.wr_act ^ b_q.cfg.strobe_inv;
	assign external_bus_grant_n = b_q.grant_n;
	assign grant_hang_n = b_q.hang_n;

	grant_float_a: assert property (@(posedge clk) disable iff (!por_s)
		!external_bus_grant_n |-> !ctrl_oe && !ext_addr_oe && !ext_data_oe)
		else $error("grant asserted while port still driven");
	grant_delay_a: assert property (@(posedge clk) disable iff (!por_s)
		$fell(external_bus_grant_n) |->
		!$past(external_bus_request_n, 3) && !$past(external_bus_request_n, 4))
		else $error("grant came too early after request");
	ext_lowest_a: assert property (@(posedge clk) disable iff (!por_s)
		(b_q.state == B_IDLE && (core_pend || dma_pend)) |=> b_q.state != B_FLOAT)
		else $error("external request won over internal request");
	one_select_a: assert property (@(posedge clk) disable iff (!por_s)
		$onehot0({b_q.bank_act, b_q.io_act, b_q.boot_act}))
		else $error("more than one space select active");
	io_local_a: assert property (@(posedge clk) disable iff (!por_s)
		b_q.io_act |-> b_q.req.addr[IO_PAGE_LSB +: PAGE_W] >= IO_EXT_FIRST)
		else $error("on-chip I/O page reached the port");
	release_a: assert property (@(posedge clk) disable iff (!por_s)
		(b_q.state == B_GRANT && !b_q.br_s2) |=> external_bus_grant_n ##1 ctrl_oe)
		else $error("grant not released after request dropped");
	hang_flag_a: assert property (@(posedge clk) disable iff (!por_s)
		(b_q.state == B_GRANT && core_pend) |=> !grant_hang_n)
		else $error("grant-hang missing while access blocked");
	stall_core_a: assert property (@(posedge clk) disable iff (!por_s)
		(b_q.state == B_GRANT) |=> !core_done)
		else $error("core access completed while bus granted away");
	dma_prio_a: assert property (@(posedge clk) disable iff (!por_s)
		dma_req[0] |-> dma_sel == 5'h01)
		else $error("receive DMA not given top priority");
	read_lock_a: assert property (@(posedge clk) disable iff (!por_s)
		(b_q.lock && b_q.state == B_IDLE) |=> b_q.state != B_FLOAT)
		else $error("grant between paired reads");
	excl_port_a: assert property (@(posedge clk) disable iff (!por_s)
		(c_q.excl && b_q.state == B_IDLE) |=>
		b_q.state != B_FLOAT && !(b_q.state == B_NEXT && b_q.owner_dma))
		else $error("exclusive core option not honoured");
	clk_rate_a: assert property (@(posedge clk) CLK_HZ <= PCLK_MAX_HZ)
		else $error("port clock above peripheral limit");
endmodule
